/* design/dvs_ctrl.sv */
// Voltage-scaling control for four step-down converters.
`timescale 1ns/100ps
`include "dvs_defines.svh"
module dvs_ctrl (
    // Clock and reset
    input  wire logic                clk_in,
    input  wire logic                rst_in,
    // Pulse-width request link
    input  wire logic                pwm_request_clock_in,
    input  wire logic                pwm_request_signal_in,
    // Strap and select pins
    input  wire logic                bank_select_pin_in,
    input  wire logic                pin_function_select_pin_in,
    input  wire logic                host_port_select_pin_in,
    input  wire logic [3:0]          voltage_select_pin_in,
    // Configuration bits
    input  wire logic [3:0]          power_bus_assign_in,
    input  wire logic [3:0]          register_select_bit_in,
    input  wire logic [3:0]          default_voltage_select_in,
    input  wire logic [3:0][1:0]     slew_step_time_in,
    input  wire logic                pwm_request_enable_in,
    input  wire logic [1:0]          pwm_request_range_in,
    input  wire logic [1:0]          limit_range_in,
    input  wire logic [1:0]          limit_max_sel_in,
    // Standard host port setting writes
    input  wire logic                std_wr_in,
    input  wire logic [1:0]          std_wr_conv_in,
    input  wire logic                std_wr_alt_in,
    input  wire logic [11:0]         std_wr_data_in,
    // Power bus port setting writes
    input  wire logic                pwr_wr_in,
    input  wire logic [1:0]          pwr_wr_conv_in,
    input  wire logic                pwr_wr_alt_in,
    input  wire logic [11:0]         pwr_wr_data_in,
    // Converter outputs
    output logic      [3:0][11:0]    vout_out,
    output logic      [3:0][11:0]    target_out,
    // Status
    output logic                     config_done_out,
    output logic                     bank_b_out,
    output logic                     spi_active_out,
    output logic                     i2c_active_out,
    output logic                     std_wr_refused_out,
    output logic                     pwr_wr_refused_out,
    output logic                     pwm_frame_valid_out,
    output logic      [1:0]          eff_range_out,
    output logic      [1:0]          eff_max_sel_out
);
    dvs_pkg::dvs_state_t state;
    dvs_pkg::dvs_volt_t  op_set  [4];
    dvs_pkg::dvs_volt_t  alt_set [4];
    dvs_pkg::dvs_volt_t  pwm_volt;
    dvs_pkg::dvs_volt_t  next_target [4];
    logic [6:0]          pin_meta;
    logic [6:0]          pin_sync;
    logic [1:0]          cfg_wait;
    logic                tog_meta;
    logic                tog_sync;
    logic                tog_prev;
    logic                frame_seen;
    logic [7:0]          ramp_cnt [4];

    dvs_frame_if frame_if ();

    dvs_pwm_decoder u_decoder (
        .pwm_request_clock_in  (pwm_request_clock_in),
        .pwm_request_signal_in (pwm_request_signal_in),
        .rst_in                (rst_in),
        .frame                 (frame_if.dec)
    );

    function automatic logic [7:0] step_cycles(input logic [1:0] code);
        integer ns;
        ns = `DVS_STEP_NS0;
        case (code)
            2'h0: ns = `DVS_STEP_NS0;
            2'h1: ns = `DVS_STEP_NS1;
            2'h2: ns = `DVS_STEP_NS2;
            2'h3: ns = `DVS_STEP_NS3;
        endcase
        step_cycles = 8'((ns + `DVS_CLK_NS - 1) / `DVS_CLK_NS);
    endfunction : step_cycles

    function automatic dvs_pkg::dvs_volt_t count_to_volt(input logic [1:0] range,
                                                         input logic [5:0] count);
        logic [11:0] vmax;
        logic [11:0] step;
        logic [17:0] drop;
        vmax = `DVS_R0_MAX;
        step = `DVS_R0_STEP;
        case (range)
            2'h0: begin vmax = `DVS_R0_MAX; step = `DVS_R0_STEP; end
            2'h1: begin vmax = `DVS_R1_MAX; step = `DVS_R1_STEP; end
            2'h2: begin vmax = `DVS_R2_MAX; step = `DVS_R2_STEP; end
            2'h3: begin vmax = `DVS_R3_MAX; step = `DVS_R3_STEP; end
        endcase
        drop = {6'h00, step} * {12'h000, count};
        if (drop >= {6'h00, vmax}) begin
            count_to_volt = 12'h000;
        end else begin
            count_to_volt = vmax - drop[11:0];
        end
        if (step == `DVS_CLAMP_STEP && count_to_volt > `DVS_CLAMP_MAX) begin
            count_to_volt = `DVS_CLAMP_MAX;
        end
    endfunction : count_to_volt

    // Straps and select pins are asynchronous to this clock.
    always_ff @(posedge clk_in) begin
        pin_meta <= {host_port_select_pin_in, pin_function_select_pin_in,
                     bank_select_pin_in, voltage_select_pin_in};
        pin_sync <= pin_meta;
    end

    // Configuration waits for the pin synchroniser before sampling the bank strap.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state    <= dvs_pkg::DVS_CFG_WAIT;
            cfg_wait <= 2'h0;
        end else begin
            unique case (state)
                dvs_pkg::DVS_CFG_WAIT: begin
                    cfg_wait <= cfg_wait + 2'h1;
                    if (cfg_wait == 2'h2) begin
                        state <= dvs_pkg::DVS_CFG_LOAD;
                    end
                end
                dvs_pkg::DVS_CFG_LOAD: begin
                    state <= dvs_pkg::DVS_ACTIVE;
                end
                dvs_pkg::DVS_ACTIVE: begin
                    state <= dvs_pkg::DVS_ACTIVE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bank_b_out <= 1'b0;
        end else if (state == dvs_pkg::DVS_CFG_LOAD) begin
            bank_b_out <= pin_sync[4];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            config_done_out <= 1'b0;
            spi_active_out  <= 1'b0;
            i2c_active_out  <= 1'b0;
        end else begin
            config_done_out <= (state == dvs_pkg::DVS_ACTIVE);
            spi_active_out  <= ~pin_sync[6];
            i2c_active_out  <= pin_sync[6];
        end
    end

    // Setting registers; the strobes are taken one per cycle, so any bus rate fits.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < 4; i++) begin
                op_set[i]  <= 12'h000;
                alt_set[i] <= 12'h000;
            end
            std_wr_refused_out <= 1'b0;
            pwr_wr_refused_out <= 1'b0;
        end else if (state == dvs_pkg::DVS_CFG_LOAD) begin
            for (int i = 0; i < 4; i++) begin
                op_set[i]  <= pin_sync[4] ? `DVS_BANK_B_OP : `DVS_BANK_A_OP;
                alt_set[i] <= pin_sync[4] ? `DVS_BANK_B_AVS : `DVS_BANK_A_AVS;
            end
        end else if (state == dvs_pkg::DVS_ACTIVE) begin
            std_wr_refused_out <= std_wr_in && (power_bus_assign_in[std_wr_conv_in] ||
                (std_wr_conv_in == 2'h0 && pwm_request_enable_in));
            pwr_wr_refused_out <= pwr_wr_in && (!power_bus_assign_in[pwr_wr_conv_in] ||
                (pwr_wr_conv_in == 2'h0 && pwm_request_enable_in));
            if (std_wr_in && !power_bus_assign_in[std_wr_conv_in] &&
                !(std_wr_conv_in == 2'h0 && pwm_request_enable_in)) begin
                if (std_wr_alt_in) begin
                    alt_set[std_wr_conv_in] <= std_wr_data_in;
                end else begin
                    op_set[std_wr_conv_in] <= std_wr_data_in;
                end
            end
            // If both ports hit the same register at once, the port that power_bus_assign_in gives the converter to wins.
            if (pwr_wr_in && power_bus_assign_in[pwr_wr_conv_in] &&
                !(pwr_wr_conv_in == 2'h0 && pwm_request_enable_in)) begin
                if (pwr_wr_alt_in) begin
                    alt_set[pwr_wr_conv_in] <= pwr_wr_data_in;
                end else begin
                    op_set[pwr_wr_conv_in] <= pwr_wr_data_in;
                end
            end
        end
    end

    // Frame toggle crossing; only the second flop feeds the edge detector.
    // Left unreset so that a toggle parked across a reset never reads as a fresh frame.
    always_ff @(posedge clk_in) begin
        tog_meta <= frame_if.toggle;
        tog_sync <= tog_meta;
        tog_prev <= tog_sync;
    end

    // The count word is stable for a whole frame after its toggle, far longer than the sync.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pwm_volt   <= 12'h000;
            frame_seen <= 1'b0;
        end else if (tog_sync != tog_prev) begin
            pwm_volt   <= count_to_volt(pwm_request_range_in, frame_if.count);
            frame_seen <= 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pwm_frame_valid_out <= 1'b0;
            eff_range_out       <= 2'h0;
            eff_max_sel_out     <= 2'h0;
        end else begin
            pwm_frame_valid_out <= frame_seen;
            eff_range_out   <= pwm_request_enable_in ? pwm_request_range_in
                                                     : limit_range_in;
            eff_max_sel_out <= pwm_request_enable_in ? 2'h0 : limit_max_sel_in;
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (pin_sync[5]) begin
                next_target[i] = (register_select_bit_in[i] && default_voltage_select_in[i])
                                 ? alt_set[i] : op_set[i];
            end else begin
                next_target[i] = pin_sync[i] ? alt_set[i] : op_set[i];
            end
        end
        if (pwm_request_enable_in) begin
            next_target[0] = pwm_volt;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < 4; i++) begin
                target_out[i] <= 12'h000;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                target_out[i] <= next_target[i];
            end
        end
    end

    // One millivolt per step keeps the ramp monotonic whatever the distance.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < 4; i++) begin
                vout_out[i] <= 12'h000;
                ramp_cnt[i] <= 8'h00;
            end
        end else if (state == dvs_pkg::DVS_CFG_LOAD) begin
            for (int i = 0; i < 4; i++) begin
                vout_out[i] <= pin_sync[4] ? `DVS_BANK_B_OP : `DVS_BANK_A_OP;
                ramp_cnt[i] <= 8'h00;
            end
        end else if (config_done_out) begin
            // Waiting one cycle past the load lets the target register catch up first.
            for (int i = 0; i < 4; i++) begin
                if (vout_out[i] == target_out[i]) begin
                    ramp_cnt[i] <= 8'h00;
                end else if (ramp_cnt[i] != 8'h00) begin
                    ramp_cnt[i] <= ramp_cnt[i] - 8'h01;
                end else begin
                    ramp_cnt[i] <= step_cycles(slew_step_time_in[i]) - 8'h01;
                    if (vout_out[i] < target_out[i]) begin
                        vout_out[i] <= vout_out[i] + 12'h001;
                    end else begin
                        vout_out[i] <= vout_out[i] - 12'h001;
                    end
                end
            end
        end
    end
endmodule : dvs_ctrl

/* shared/dvs_defines.svh */
// Constants for the voltage-scaling control block.
`ifndef DVS_DEFINES_SVH
`define DVS_DEFINES_SVH

`define DVS_NUM_CONV        4
`define DVS_VOLT_W          12
`define DVS_CLK_NS          20
`define DVS_FRAME_CYCLES    5'h1f
`define DVS_COUNT_W         6

`define DVS_BANK_A_OP       12'h3e8
`define DVS_BANK_A_AVS      12'h44c
`define DVS_BANK_B_OP       12'h4b0
`define DVS_BANK_B_AVS      12'h514

`define DVS_STEP_NS0        100
`define DVS_STEP_NS1        200
`define DVS_STEP_NS2        400
`define DVS_STEP_NS3        800

`define DVS_R0_MAX          12'h4fb
`define DVS_R0_STEP         12'h019
`define DVS_R1_MAX          12'h640
`define DVS_R1_STEP         12'h00a
`define DVS_R2_MAX          12'h708
`define DVS_R2_STEP         12'h032
`define DVS_R3_MAX          12'hce4
`define DVS_R3_STEP         12'h064
`define DVS_CLAMP_STEP      12'h019
`define DVS_CLAMP_MAX       12'h44c

`endif

/* shared/dvs_pkg.sv */
// Types shared by the voltage-scaling control block.
package dvs_pkg;
    typedef logic [11:0] dvs_volt_t;
    typedef enum logic [2:0] {
        DVS_CFG_WAIT = 3'b001,
        DVS_CFG_LOAD = 3'b010,
        DVS_ACTIVE   = 3'b100
    } dvs_state_t;
endpackage : dvs_pkg

/* shared/dvs_frame_if.sv */
// Carrier for decoded frame counts from the request-clock domain.
`timescale 1ns/100ps
interface dvs_frame_if;
    logic [5:0] count;
    logic       toggle;
    modport dec (output count, output toggle);
    modport ctl (input count, input toggle);
endinterface : dvs_frame_if

/* design/dvs_pwm_decoder.sv */
// Pulse-width request decoder running on the request clock.
`timescale 1ns/100ps
`include "dvs_defines.svh"
module dvs_pwm_decoder (
    // Request link
    input  wire logic pwm_request_clock_in,
    input  wire logic pwm_request_signal_in,
    // Reset from the main domain
    input  wire logic rst_in,
    // Frame result
    dvs_frame_if.dec  frame
);
    logic       rst_meta;
    logic       rst_link;
    logic       sig;
    logic [4:0] cyc;
    logic [5:0] high_cnt;

    // Reset is brought over on the link clock so that no flop sees a foreign edge.
    always_ff @(posedge pwm_request_clock_in) begin
        rst_meta <= rst_in;
        rst_link <= rst_meta;
    end

    always_ff @(posedge pwm_request_clock_in) begin
        sig <= pwm_request_signal_in;
    end

    // The clock may stop between frames; a partial frame simply resumes later.
    always_ff @(posedge pwm_request_clock_in) begin
        if (rst_link) begin
            cyc          <= 5'h00;
            high_cnt     <= 6'h00;
            frame.count  <= 6'h00;
            frame.toggle <= 1'b0;
        end else begin
            cyc <= cyc + 5'h01;
            if (cyc == `DVS_FRAME_CYCLES) begin
                frame.count  <= high_cnt + {5'h00, sig};
                frame.toggle <= ~frame.toggle;
                high_cnt     <= 6'h00;
            end else begin
                high_cnt <= high_cnt + {5'h00, sig};
            end
        end
    end
endmodule : dvs_pwm_decoder

/* testbench/dvs_ctrl_chk.sv */
// Concurrent checks on the ports of the voltage-scaling control block.
`timescale 1ns/100ps
module dvs_ctrl_chk (
    // Clock and reset
    input wire logic             clk_in,
    input wire logic             rst_in,
    // Pins and configuration
    input wire logic             host_port_select_pin_in,
    input wire logic             pwm_request_enable_in,
    input wire logic             std_wr_in,
    input wire logic             pwr_wr_in,
    input wire logic [3:0]       power_bus_assign_in,
    input wire logic [3:0][1:0]  slew_step_time_in,
    input wire logic [1:0]       limit_range_in,
    input wire logic [1:0]       limit_max_sel_in,
    input wire logic [1:0]       std_wr_conv_in,
    input wire logic [1:0]       pwr_wr_conv_in,
    // Observed outputs
    input wire logic             config_done_out,
    input wire logic             bank_b_out,
    input wire logic             spi_active_out,
    input wire logic             i2c_active_out,
    input wire logic             std_wr_refused_out,
    input wire logic             pwr_wr_refused_out,
    input wire logic             pwm_frame_valid_out,
    input wire logic [1:0]       eff_range_out,
    input wire logic [1:0]       eff_max_sel_out,
    input wire logic [3:0][11:0] vout_out
);
    wire act = config_done_out;

    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_std_refuse: assert property (act && std_wr_in && power_bus_assign_in[std_wr_conv_in]
        |=> std_wr_refused_out) else $error("standard write not refused");
    a_pwr_refuse: assert property (act && pwr_wr_in && !power_bus_assign_in[pwr_wr_conv_in]
        |=> pwr_wr_refused_out) else $error("power write not refused");
    a_std_accept: assert property (act && std_wr_in && !power_bus_assign_in[std_wr_conv_in]
        && !(pwm_request_enable_in && std_wr_conv_in == 2'h0) |=> !std_wr_refused_out)
        else $error("standard write wrongly refused");
    a_pwm_block: assert property (act && std_wr_in && pwm_request_enable_in
        && std_wr_conv_in == 2'h0 |=> std_wr_refused_out) else $error("write not blocked");
    a_host_port: assert property ($stable(host_port_select_pin_in)[*4] ##0 act
        |-> i2c_active_out == host_port_select_pin_in
        && spi_active_out == !host_port_select_pin_in) else $error("host port mismatch");
    a_bank_hold: assert property (act && $past(act) |-> $stable(bank_b_out))
        else $error("bank changed after configuration");
    a_cfg_seq: assert property ($fell(rst_in) |-> !act[*3] ##[1:4] act)
        else $error("configuration sequence length wrong");
    // Checked on one converter only, whose target is never moved mid-ramp by the bench.
    a_slew_rate: assert property (act && $past(act) && $changed(vout_out[3])
        && slew_step_time_in[3] == 2'h1 |=> !$changed(vout_out[3])[*8])
        else $error("ramp step too fast");
    a_pwm_maxsel: assert property ($stable(pwm_request_enable_in)[*3] ##0
        pwm_request_enable_in && act |-> eff_max_sel_out == 2'h0) else $error("max select used");
    a_limit_echo: assert property ($stable({pwm_request_enable_in, limit_range_in,
        limit_max_sel_in})[*3] ##0 !pwm_request_enable_in && act |-> eff_range_out ==
        limit_range_in && eff_max_sel_out == limit_max_sel_in) else $error("limit not restored");

    c_refused: cover property (std_wr_refused_out);
    c_pwm: cover property (pwm_request_enable_in && pwm_frame_valid_out);
    c_ramp: cover property (act && $changed(vout_out[3]));
endmodule : dvs_ctrl_chk

/* testbench/dvs_req_model.sv */
// Far-side source of the pulse-width request link.
`timescale 1ns/100ps
module dvs_req_model (
    // Request link
    output logic req_clk_out,
    output logic req_sig_out
);
    initial begin
        req_clk_out = 1'b0;
        req_sig_out = 1'b0;
    end
    // The high window sits mid-frame, so edges lost while the decoder leaves reset
    // cannot push it across a frame boundary. Clock stands still between calls.
    task automatic send(input int highs);
        for (int i = 0; i < 64; i++) begin
            req_sig_out = (i % 32 >= 12) && (i % 32 < 12 + highs);
            #17 req_clk_out = 1'b1;
            #17 req_clk_out = 1'b0;
        end
        req_sig_out = ~req_sig_out;
    endtask : send
endmodule : dvs_req_model

/* testbench/tb_top.sv */
// Top-level bench for the voltage-scaling control block.
`timescale 1ns/100ps
`include "dvs_defines.svh"
module tb_top;
    logic clk_in = 1'b0, rst_in = 1'b1, bank_select_pin_in = 1'b0;
    logic pin_function_select_pin_in = 1'b1, host_port_select_pin_in = 1'b0;
    logic pwm_request_enable_in = 1'b0, std_wr_in = 1'b0, std_wr_alt_in = 1'b0;
    logic pwr_wr_in = 1'b0, pwr_wr_alt_in = 1'b0, pwm_request_clock_in, pwm_request_signal_in;
    logic [3:0] voltage_select_pin_in = 4'h0, power_bus_assign_in = 4'h0;
    logic [3:0] register_select_bit_in = 4'h0, default_voltage_select_in = 4'h0;
    logic [3:0][1:0] slew_step_time_in = 8'h40;
    logic [1:0] pwm_request_range_in = 2'h0, limit_range_in = 2'h2, limit_max_sel_in = 2'h3;
    logic [1:0] std_wr_conv_in = 2'h0, pwr_wr_conv_in = 2'h0;
    logic [11:0] std_wr_data_in = 12'h000, pwr_wr_data_in = 12'h000;
    logic [3:0][11:0] vout_out, target_out;
    logic config_done_out, bank_b_out, spi_active_out, i2c_active_out;
    logic std_wr_refused_out, pwr_wr_refused_out, pwm_frame_valid_out;
    logic [1:0] eff_range_out, eff_max_sel_out;
    logic [11:0] mx [4] = '{`DVS_R0_MAX, `DVS_R1_MAX, `DVS_R2_MAX, `DVS_R3_MAX};
    logic [11:0] st [4] = '{`DVS_R0_STEP, `DVS_R1_STEP, `DVS_R2_STEP, `DVS_R3_STEP};
    int n_fail = 0;
    int checked = 0;
    logic r;

    dvs_ctrl uut (.*);
    dvs_req_model model (.req_clk_out(pwm_request_clock_in), .req_sig_out(pwm_request_signal_in));

    initial begin
        forever #10 clk_in = ~clk_in;
    end

    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask : check

    task automatic wr(input logic p, input logic [1:0] c, input logic [11:0] d);
        @(negedge clk_in);
        if (p) {pwr_wr_in, pwr_wr_conv_in, pwr_wr_data_in} = {1'b1, c, d};
        else {std_wr_in, std_wr_conv_in, std_wr_data_in} = {1'b1, c, d};
        @(negedge clk_in);
        r = p ? pwr_wr_refused_out : std_wr_refused_out;
        {pwr_wr_in, std_wr_in} = 2'b00;
        repeat (4) @(negedge clk_in);
    endtask : wr

    function automatic logic [11:0] volt(input int g, input int n);
        logic [11:0] v;
        v = mx[g] - 12'(n) * st[g];
        if (st[g] == `DVS_CLAMP_STEP && v > `DVS_CLAMP_MAX) v = `DVS_CLAMP_MAX;
        return v;
    endfunction : volt

    task automatic test_done;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done

    initial begin
        #400000;
        n_fail++;
        test_done;
    end

    initial begin
        fork
            begin
                repeat (16) @(negedge clk_in);
                rst_in = 1'b0;
            end
            model.send(0);
        join
        @(negedge clk_in);
        check(target_out[3], `DVS_BANK_A_OP);
        check({11'h0, bank_b_out}, 12'h000);
        check({11'h0, spi_active_out}, 12'h001);
        check({11'h0, config_done_out}, 12'h001);
        host_port_select_pin_in = 1'b1;
        repeat (4) @(negedge clk_in);
        check({11'h0, i2c_active_out}, 12'h001);
        wr(1'b0, 2'h1, 12'h4d2);
        check({11'h0, r}, 12'h000);
        check(target_out[1], 12'h4d2);
        register_select_bit_in = 4'h2;
        repeat (4) @(negedge clk_in);
        check(target_out[1], 12'h4d2);
        default_voltage_select_in = 4'h2;
        repeat (4) @(negedge clk_in);
        check(target_out[1], `DVS_BANK_A_AVS);
        std_wr_alt_in = 1'b1;
        wr(1'b0, 2'h1, 12'h567);
        std_wr_alt_in = 1'b0;
        check(target_out[1], 12'h567);
        power_bus_assign_in = 4'h4;
        wr(1'b0, 2'h2, 12'h111);
        check({11'h0, r}, 12'h001);
        wr(1'b1, 2'h2, 12'h3ff);
        check({11'h0, r}, 12'h000);
        check(target_out[2], 12'h3ff);
        pwr_wr_alt_in = 1'b1;
        wr(1'b1, 2'h2, 12'h456);
        pwr_wr_alt_in = 1'b0;
        check({11'h0, r}, 12'h000);
        wr(1'b1, 2'h3, 12'h222);
        check({11'h0, r}, 12'h001);
        pin_function_select_pin_in = 1'b0;
        voltage_select_pin_in = 4'h4;
        repeat (4) @(negedge clk_in);
        check(target_out[2], 12'h456);
        check(target_out[1], 12'h4d2);
        voltage_select_pin_in = 4'h0;
        repeat (4) @(negedge clk_in);
        check(target_out[2], 12'h3ff);
        wr(1'b0, 2'h3, `DVS_BANK_A_OP + 12'h00a);
        repeat (40) @(negedge clk_in);
        check({11'h0, vout_out[3] > `DVS_BANK_A_OP && vout_out[3] < `DVS_BANK_A_OP + 12'h00a},
              12'h001);
        repeat (100) @(negedge clk_in);
        check(vout_out[3], `DVS_BANK_A_OP + 12'h00a);
        model.send(8);
        @(negedge clk_in);
        pwm_request_enable_in = 1'b1;
        repeat (8) @(negedge clk_in);
        check(target_out[0], volt(0, 8));
        for (int g = 1; g < 4; g++) begin
            pwm_request_range_in = 2'(g);
            model.send(8);
            repeat (8) @(negedge clk_in);
            check(target_out[0], volt(g, 8));
        end
        pwm_request_range_in = 2'h0;
        for (int n = 0; n < 8; n += 7) begin
            model.send(n);
            repeat (8) @(negedge clk_in);
            check(target_out[0], `DVS_CLAMP_MAX);
        end
        check({10'h0, eff_max_sel_out}, 12'h000);
        check({11'h0, pwm_frame_valid_out}, 12'h001);
        wr(1'b0, 2'h0, 12'h123);
        check({11'h0, r}, 12'h001);
        check(target_out[0], `DVS_CLAMP_MAX);
        pwm_request_enable_in = 1'b0;
        repeat (4) @(negedge clk_in);
        check(target_out[0], `DVS_BANK_A_OP);
        check({10'h0, eff_range_out}, 12'h002);
        bank_select_pin_in = 1'b1;
        rst_in = 1'b1;
        repeat (16) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (8) @(negedge clk_in);
        check({11'h0, bank_b_out}, 12'h001);
        check(target_out[2], `DVS_BANK_B_OP);
        check({11'h0, pwm_frame_valid_out}, 12'h000);
        bank_select_pin_in = 1'b0;
        repeat (4) @(negedge clk_in);
        check({11'h0, bank_b_out}, 12'h001);
        test_done;
    end
endmodule : tb_top

bind dvs_ctrl dvs_ctrl_chk chk (.*);
